// ---- hdl/spsdp_port.sv ----
// Serial peripheral status and data port: registers, flags, shifter.
// Assumes a one-cycle register port and pins sampled through synchronisers.
`timescale 1ns/1ps
`default_nettype none

module spsdp_port (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [spsdp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [spsdp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [spsdp_pkg::DATA_W-1:0] reg_rdata,
    output logic irq,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i,
    output logic ss_pin_free
);
    import spsdp_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] ctrl_q; // Control register
    logic [2:0] csr_sw_q; // Output disable, soft select, select level
    logic done_q; // Transfer done flag
    logic write_collision_flag_q; // Write collision flag
    logic ovr_q; // Overrun flag
    logic master_fault_flag_q; // Master fault flag
    logic seq_armed_q; // Status read seen, data access pending
    logic master_fault_flag_armed_q; // Status read with fault set
    logic [7:0] rx_buf_q; // Receive buffer, left unreset
    logic [7:0] sh_q; // Shift register, left unreset
    logic out_q; // Bit presented on the data output
    logic [2:0] bit_cnt_q; // Captured bits of current byte
    logic [IRQ_W-1:0] irq_stat_q; // Sticky event bits
    logic [IRQ_W-1:0] irq_mask_q; // Event mask
    logic [7:0] rdata_q; // Read data, one cycle after strobe
    spsdp_state_type state_q; // Master sequencer
    logic [5:0] div_cnt_q; // Half-period countdown
    logic [3:0] tog_cnt_q; // Clock toggles issued
    logic sck_q; // Generated serial clock
    logic sck_prev_q; // Last synced clock level in slave mode

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_s;

    spsdp_sync #(.RST_VAL(1'b0)) u_sync_sck
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(sck_i),
        .q(sck_s)
    );

    spsdp_sync #(.RST_VAL(1'b0)) u_sync_mosi
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(mosi_i),
        .q(mosi_s)
    );

    spsdp_sync #(.RST_VAL(1'b0)) u_sync_miso
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(miso_i),
        .q(miso_s)
    );

    // Select idles high so a reset never looks like a fault
    spsdp_sync #(.RST_VAL(1'b1)) u_sync_ss
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(ss_n_i),
        .q(ss_s)
    );

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    // five byte addresses
    wire wr_data = reg_wr && (reg_addr == ADDR_DATA);
    wire rd_data = reg_rd && (reg_addr == ADDR_DATA);
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    wire rd_csr = reg_rd && (reg_addr == ADDR_CSR);
    wire wr_csr = reg_wr && (reg_addr == ADDR_CSR);
    wire wr_istat = reg_wr && (reg_addr == ADDR_IRQ_STAT);
    wire wr_imask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
    wire dr_access = wr_data || rd_data;

    // Configuration fields
    wire irq_en = ctrl_q[CR_IRQ_EN];
    wire port_en = ctrl_q[CR_PORT_EN];
    wire master = ctrl_q[CR_MASTER];
    wire cpol = ctrl_q[CR_CPOL];
    wire cpha = ctrl_q[CR_CPHA];
    wire odis = csr_sw_q[CSR_ODIS];
    wire select_source_soft = csr_sw_q[CSR_SSM];
    wire soft_select_level = csr_sw_q[CSR_SSI];
    wire [2:0] spr = {ctrl_q[CR_SPR2], ctrl_q[CR_SPR1], ctrl_q[CR_SPR0]};

    // ----------------------------------------
    // Slave select
    // ----------------------------------------
    // pick select source
    wire ss_int = select_source_soft ? soft_select_level : ss_s;
    wire slave_sel = port_en && !master && !ss_int;
    assign ss_pin_free = select_source_soft;

    // ----------------------------------------
    // Transfer control
    // ----------------------------------------
    wire master_run = (state_q == ST_RUN);
    // A slave counts as busy once its first bit is in
    wire busy = master ? master_run : (slave_sel && (bit_cnt_q != 3'h0));
    wire wr_blocked = done_q && !seq_armed_q;
    wire write_collision_flag_ev = wr_data && !wr_blocked && busy;
    wire load_ev = wr_data && !wr_blocked && !busy;
    wire start_ev = load_ev && master && port_en;
    wire master_fault_flag_ev = port_en && master && !ss_int;

    // ----------------------------------------
    // Serial clock edges
    // ----------------------------------------
    wire m_tog = master_run && (div_cnt_q == 6'h00);
    wire m_lead = m_tog && (sck_q == cpol);
    wire m_trail = m_tog && (sck_q != cpol);
    wire s_edge = slave_sel && (sck_s != sck_prev_q);
    wire s_lead = s_edge && (sck_prev_q == cpol);
    wire s_trail = s_edge && (sck_prev_q != cpol);
    wire lead_ev = master ? m_lead : s_lead;
    wire trail_ev = master ? m_trail : s_trail;
    // Phase picks which edge samples and which one drives
    wire cap_ev = cpha ? trail_ev : lead_ev;
    wire drv_ev = cpha ? lead_ev : trail_ev;
    wire ser_in = master ? miso_s : mosi_s;
    wire [7:0] rx_next = {sh_q[6:0], ser_in};
    wire done_ev = cap_ev && (bit_cnt_q == BIT_LAST);
    wire ovr_ev = done_ev && done_q;

    // ----------------------------------------
    // Flag clearing sequences
    // ----------------------------------------
    // status read then data access
    wire done_clr = seq_armed_q && dr_access;
    wire ovr_clr = rd_csr;
    wire master_fault_flag_clr = master_fault_flag_armed_q && wr_ctrl;

    // ----------------------------------------
    // Divider selection
    // ----------------------------------------
    // Half-period reload, one less than the half period in core cycles, for each rate code
    function automatic logic [5:0] div_reload(input logic [2:0] code);
        logic [5:0] r;
        r = DIV_RLD_128;
        case (code)
            3'h4: r = DIV_RLD_4;
            3'h0: r = DIV_RLD_8;
            3'h1: r = DIV_RLD_16;
            3'h5: r = DIV_RLD_16;
            3'h6: r = DIV_RLD_32;
            3'h2: r = DIV_RLD_64;
            default: r = DIV_RLD_128;
        endcase
        return r;
    endfunction

    wire [5:0] div_rld = div_reload(spr);

    // ----------------------------------------
    // Read multiplexer
    // ----------------------------------------
    // Reserved bit reads as zero
    wire [7:0] csr_rd = {done_q, write_collision_flag_q, ovr_q, master_fault_flag_q, CSR_RSVD_VAL, csr_sw_q};
    wire [7:0] rd_mux =
        (reg_addr == ADDR_DATA) ? rx_buf_q :
        (reg_addr == ADDR_CTRL) ? ctrl_q :
        (reg_addr == ADDR_CSR) ? csr_rd :
        (reg_addr == ADDR_IRQ_STAT) ? {5'h00, irq_stat_q} :
        (reg_addr == ADDR_IRQ_MASK) ? {5'h00, irq_mask_q} : 8'h00;
    wire [IRQ_W-1:0] irq_ev = {done_ev, ovr_ev, master_fault_flag_ev};
    wire [IRQ_W-1:0] istat_clr = wr_istat ? reg_wdata[IRQ_W-1:0] : IRQ_RST;

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    // Software write first, a fault overrides it
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl_q <= CTRL_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q <= reg_wdata;
            end
            if (master_fault_flag_ev)
            begin
                ctrl_q[CR_PORT_EN] <= 1'b0;
                ctrl_q[CR_MASTER] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Set terms win over clears in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            csr_sw_q <= CSR_SW_RST;
            done_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            ovr_q <= 1'b0;
            master_fault_flag_q <= 1'b0;
            seq_armed_q <= 1'b0;
            master_fault_flag_armed_q <= 1'b0;
        end
        else
        begin
            // Only the low three bits are writable
            if (wr_csr)
            begin
                csr_sw_q <= reg_wdata[2:0];
            end
            done_q <= done_ev || (done_q && !done_clr);
            write_collision_flag_q <= write_collision_flag_ev || (write_collision_flag_q && !done_clr);
            ovr_q <= ovr_ev || (ovr_q && !ovr_clr);
            master_fault_flag_q <= master_fault_flag_ev || (master_fault_flag_q && !master_fault_flag_clr);
            seq_armed_q <= rd_csr || (seq_armed_q && !dr_access);
            master_fault_flag_armed_q <= (rd_csr && master_fault_flag_q) || (master_fault_flag_armed_q && !wr_ctrl);
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    // Write one to clear; a new event wins
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            irq_stat_q <= IRQ_RST;
            irq_mask_q <= IRQ_RST;
        end
        else
        begin
            irq_stat_q <= irq_ev | (irq_stat_q & ~istat_clr);
            if (wr_imask)
            begin
                irq_mask_q <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    assign irq = irq_en && (|(irq_stat_q & irq_mask_q));

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Data stands for exactly one cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // Shift register and receive buffer
    // ----------------------------------------
    // No transmit buffer, so a write lands in the shifter at once
    always_ff @(posedge ref_clk)
    begin
        if (load_ev)
        begin
            sh_q <= reg_wdata;
        end
        else if (cap_ev)
        begin
            sh_q <= rx_next;
        end
        if (done_ev && !done_q)
        begin
            rx_buf_q <= rx_next;
        end
    end

    // Bit counter and output bit
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            bit_cnt_q <= 3'h0;
            out_q <= 1'b0;
        end
        else
        begin
            if (load_ev || (!master && !slave_sel))
            begin
                // Deselect aborts a partial slave byte
                bit_cnt_q <= 3'h0;
            end
            else if (cap_ev)
            begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            // Phase zero shows the first bit before any edge
            if (load_ev && !cpha)
            begin
                out_q <= reg_wdata[7];
            end
            else if (drv_ev)
            begin
                out_q <= sh_q[7];
            end
        end
    end

    // ----------------------------------------
    // Master clock sequencer
    // ----------------------------------------
    // Sixteen toggles make one byte; a fault aborts the byte
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            div_cnt_q <= 6'h00;
            tog_cnt_q <= 4'h0;
            sck_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    // Clock rests at its idle polarity
                    sck_q <= cpol;
                    tog_cnt_q <= 4'h0;
                    div_cnt_q <= div_rld;
                    if (start_ev && !master_fault_flag_ev)
                    begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (master_fault_flag_ev)
                    begin
                        state_q <= ST_IDLE;
                    end
                    else if (m_tog)
                    begin
                        sck_q <= !sck_q;
                        div_cnt_q <= div_rld;
                        tog_cnt_q <= tog_cnt_q + 4'h1;
                        if (tog_cnt_q == TOG_LAST)
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                    else
                    begin
                        div_cnt_q <= div_cnt_q - 6'h01;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Slave mode edge finder
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sck_prev_q <= 1'b0;
        end
        else
        begin
            sck_prev_q <= sck_s;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    assign sck_o = sck_q;
    assign sck_oe = port_en && master;
    assign mosi_o = out_q;
    assign mosi_oe = port_en && master && !odis;
    // Slave drives only while selected to avoid bus fights
    assign miso_o = out_q;
    assign miso_oe = slave_sel && !odis;

endmodule

`default_nettype wire

// ---- pkg/spsdp_pkg.sv ----
// Constants shared by the serial status and data port block.
// Assumes an 8-bit register port and a single 50 MHz core clock.
package spsdp_pkg;

    // ----------------------------------------
    // Register port geometry
    // ----------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_DATA = 8'h31;
    localparam logic [7:0] ADDR_CTRL = 8'h32;
    localparam logic [7:0] ADDR_CSR = 8'h33;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h34;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h35;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int unsigned CR_IRQ_EN = 7;
    localparam int unsigned CR_PORT_EN = 6;
    localparam int unsigned CR_SPR2 = 5;
    localparam int unsigned CR_MASTER = 4;
    localparam int unsigned CR_CPOL = 3;
    localparam int unsigned CR_CPHA = 2;
    localparam int unsigned CR_SPR1 = 1;
    localparam int unsigned CR_SPR0 = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // ----------------------------------------
    // Control/status register fields
    // ----------------------------------------
    localparam int unsigned CSR_DONE = 7;
    localparam int unsigned CSR_WRITE_COLLISION_FLAG = 6;
    localparam int unsigned CSR_OVR = 5;
    localparam int unsigned CSR_MASTER_FAULT_FLAG = 4;
    localparam int unsigned CSR_ODIS = 2;
    localparam int unsigned CSR_SSM = 1;
    localparam int unsigned CSR_SSI = 0;
    localparam logic [2:0] CSR_SW_RST = 3'h0;
    localparam logic CSR_RSVD_VAL = 1'b0;

    // ----------------------------------------
    // Interrupt status and mask layout
    // ----------------------------------------
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_DONE = 2;
    localparam int unsigned IRQ_OVR = 1;
    localparam int unsigned IRQ_MASTER_FAULT_FLAG = 0;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // ----------------------------------------
    // Shift sequencing
    // ----------------------------------------
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] TOG_LAST = 4'hf;

    // Half-period reload values for the master clock divider
    localparam logic [5:0] DIV_RLD_4 = 6'h01;
    localparam logic [5:0] DIV_RLD_8 = 6'h03;
    localparam logic [5:0] DIV_RLD_16 = 6'h07;
    localparam logic [5:0] DIV_RLD_32 = 6'h0f;
    localparam logic [5:0] DIV_RLD_64 = 6'h1f;
    localparam logic [5:0] DIV_RLD_128 = 6'h3f;

    // Master sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } spsdp_state_type;

endpackage

// ---- hdl/spsdp_sync.sv ----
// Two-stage synchroniser for one asynchronous pin.
// Assumes the pin is unrelated to ref_clk; only q may be read.
`timescale 1ns/1ps
`default_nettype none

module spsdp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic d,
    output logic q
);

    // ----------------------------------------
    // Stages
    // ----------------------------------------
    // First stage, read only by the second
    logic meta_q;

    // Both stages reset to the idle level of the pin
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ---- tb/spsdp_slave_model.sv ----
// Behavioural serial slave standing on the far side of the port.
// Assumes clock polarity 0 and phase 0; its select is driven by the bench.
`timescale 1ns/1ps
`default_nettype none

module spsdp_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte,
    output logic [3:0] bit_cnt
);
    // ----------------------------------------
    // Shift state
    // ----------------------------------------
    logic [7:0] shreg; // Outgoing bits, MSB first

    initial
    begin
        miso = 1'b0;
        rx_byte = 8'h00;
        bit_cnt = 4'h0;
        shreg = 8'h00;
    end

    // Selection presents the first bit before the first edge
    always @(negedge sel_n)
    begin
        shreg = tx_byte;
        miso = tx_byte[7];
        bit_cnt = 4'h0;
    end

    // Capture on the leading edge
    always @(posedge sck)
    begin
        if (!sel_n)
        begin
            rx_byte = {rx_byte[6:0], mosi};
            bit_cnt = bit_cnt + 4'h1;
        end
    end

    // Next bit on the trailing edge
    always @(negedge sck)
    begin
        if (!sel_n)
        begin
            shreg = {shreg[6:0], 1'b0};
            miso = shreg[7];
        end
    end

    // Released line: no pull, so show the inverse rather than a stale bit
    always @(posedge sel_n)
        miso = ~miso;
endmodule
`default_nettype wire

// ---- tb/spsdp_port_asserts.sv ----
// Port-level assertions for the serial status and data port.
// Assumes one clock domain and the synchronous reset srst.
`timescale 1ns/1ps
`default_nettype none

module spsdp_port_asserts (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic irq,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_i,
    input wire logic ss_pin_free
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_reserved_reads_zero: assert property (reg_rd && reg_addr == 8'h33 |=> !reg_rdata[3])
        else $error("reserved status bit reads one");
    a_unmapped_reads_zero: assert property (
        reg_rd && (reg_addr < 8'h31 || reg_addr > 8'h35) |=> reg_rdata == 8'h00)
        else $error("unmapped address returned data");
    a_outputs_exclusive: assert property (!(mosi_oe && miso_oe))
        else $error("both data outputs driven");
    a_disable_stops_mosi: assert property (
        reg_rd && reg_addr == 8'h33 |=> !(reg_rdata[2] && mosi_oe))
        else $error("data out driven while disabled");
    a_mosi_needs_master: assert property (mosi_oe |-> sck_oe)
        else $error("data out driven outside master mode");
    a_pin_free_follows: assert property (
        reg_wr && reg_addr == 8'h33 |=> ss_pin_free == $past(reg_wdata[1]))
        else $error("pin release does not follow soft select");
    a_fault_drops_drive: assert property (
        $fell(ss_n_i) && sck_oe && !ss_pin_free |-> ##[1:5] !sck_oe)
        else $error("master drive kept after select fault");
    a_sck_half_min: assert property ($changed(sck_o) |=> $stable(sck_o))
        else $error("serial clock half period too short");
    a_irq_needs_enable: assert property (
        reg_rd && reg_addr == 8'h32 |=> !(irq && !reg_rdata[7]))
        else $error("interrupt raised with enable clear");
endmodule
`default_nettype wire

bind spsdp_port spsdp_port_asserts spsdp_port_asserts_inst (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .ss_n_i(ss_n_i), .ss_pin_free(ss_pin_free));

// ---- tb/testbench.sv ----
// Self-checking bench for the serial status and data port.
// Assumes the slave model on the serial side and a 50 MHz core clock.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import spsdp_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk, srst, reg_wr, reg_rd, irq, sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe;
    logic miso, miso_o, miso_oe, ss_n_i, ss_pin_free, sel_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pt, tx, prx;
    logic [3:0] pcnt;
    int n_mismatch, total_checks, seed;

    spsdp_port spsdp_port_inst (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso), .miso_o(miso_o),
        .miso_oe(miso_oe), .ss_n_i(ss_n_i), .ss_pin_free(ss_pin_free));

    // Undriven clock pin is pulled to its idle level
    spsdp_slave_model spsdp_slave_model_inst (.sck(sck_oe & sck_o), .mosi(mosi_o),
        .sel_n(sel_n), .tx_byte(pt), .miso(miso), .rx_byte(prx), .bit_cnt(pcnt));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe gap avoids two assignments to one strobe in a time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
        @(posedge ref_clk);
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 500)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk({7'h0, irq}, 8'h01);
    endtask

    // Bench acts as master: 160 ns clock, stands still between bytes
    task automatic slave_byte(input logic [7:0] b);
        for (int k = 7; k >= 0; k--)
        begin
            mosi_i <= b[k];
            repeat (4) @(posedge ref_clk);
            sck_i <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sck_i <= 1'b0;
        end
        mosi_i <= ~b[0];
        // Let an edge pass so the next byte never drives mosi twice in one step
        @(posedge ref_clk);
    endtask

    task automatic print_verdict;
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {reg_wr, reg_rd, sck_i, mosi_i} = 4'h0;
        {reg_addr, reg_wdata, pt} = 24'h0;
        {srst, ss_n_i, sel_n} = 3'h7;
        seed = 32'hae74c321;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 8'h32; a <= 8'h36; a++)
            rd(a[7:0], 8'h00);
        wr(8'h35, 8'h07);
        wr(8'h32, 8'hd0);
        wr(8'h33, 8'h04);
        chk({7'h0, mosi_oe}, 8'h00);
        wr(8'h33, 8'h03);
        chk({7'h0, ss_pin_free}, 8'h01);
        wr(8'h33, 8'h00);
        chk({7'h0, mosi_oe}, 8'h01);
        // Master bytes, odd ones with a collision
        for (int i = 0; i < 4; i++)
        begin
            tx = (i == 0) ? 8'h00 : 8'($random(seed));
            pt = (i == 0) ? 8'hff : 8'($random(seed));
            sel_n <= 1'b0;
            @(posedge ref_clk);
            wr(8'h31, tx);
            if (i % 2 == 1)
                wr(8'h31, ~tx);
            wait_irq();
            wr(8'h31, tx ^ 8'h5a);
            repeat (40) @(posedge ref_clk);
            chk({4'h0, pcnt}, 8'h08);
            chk(prx, tx);
            rd(8'h33, (i % 2 == 1) ? 8'hc0 : 8'h80);
            rd(8'h31, pt);
            rd(8'h33, 8'h00);
            if (i == 3)
            begin
                wr(8'h35, 8'h00);
                chk({7'h0, irq}, 8'h00);
                wr(8'h35, 8'h07);
            end
            wr(8'h34, 8'h07);
            chk({7'h0, irq}, 8'h00);
            sel_n <= 1'b1;
            // Deselect must be seen before the next select reloads the model
            @(posedge ref_clk);
        end
        // Mode fault from the select pin
        ss_n_i <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk({7'h0, sck_oe}, 8'h00);
        rd(8'h33, 8'h10);
        rd(8'h32, 8'h80);
        ss_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wr(8'h32, 8'hd0);
        rd(8'h33, 8'h00);
        // Slave mode, soft select, two bytes unread
        wr(8'h32, 8'h40);
        wr(8'h33, 8'h03);
        chk({7'h0, miso_oe}, 8'h00);
        wr(8'h33, 8'h02);
        chk({7'h0, miso_oe}, 8'h01);
        tx = 8'($random(seed));
        // Slave preload shows its first bit on the data output at once
        wr(8'h31, pt);
        chk({7'h0, miso_o}, {7'h0, pt[7]});
        slave_byte(tx);
        slave_byte(~tx);
        repeat (10) @(posedge ref_clk);
        rd(8'h33, 8'ha2);
        rd(8'h31, tx);
        rd(8'h33, 8'h02);
        print_verdict();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
